// ---- bench/atcs_top_sva.sv ----
// assertion checker for the trigger, compare and status block
module atcs_top_sva
  import atcs_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
) (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       hardware_trigger_input_i,
  input wire logic [7:0] rdata_o,
  input wire logic       conv_active_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cfg_ff;
  logic [7:0] cnt_ff;
  wire        sc1_wr = wr_i && addr_i == ADDR_SC1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // shadow of the config bits; an sc1 write restarts in software mode and aborts in hardware mode, so count restarts
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff <= 3'h0;
      cnt_ff <= 8'h00;
    end else begin
      if (wr_i && addr_i == ADDR_SC2) cfg_ff <= wdata_i[6:4];
      cnt_ff <= (conv_active_o && !sc1_wr) ? cnt_ff + 8'h01 : 8'h00;
    end
  end
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_RSV_ZERO: assert property (
    rd_i && addr_i == ADDR_SC2 |=> rdata_o[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  AST_ACT_READ: assert property (
    rd_i && addr_i == ADDR_SC2 |=> rdata_o[7] == $past(conv_active_o))
    else $error("active bit differs from active output");
  AST_CFG_READ: assert property (
    rd_i && addr_i == ADDR_SC2 |=> rdata_o[6:4] == $past(cfg_ff))
    else $error("config bits lost");
  AST_SW_START: assert property (
    sc1_wr && !cfg_ff[2] && !conv_active_o |-> ##2 conv_active_o)
    else $error("software start missing");
  AST_HW_NO_SW: assert property (
    sc1_wr && cfg_ff[2] && !conv_active_o && !hardware_trigger_input_i
    |-> ##2 !conv_active_o)
    else $error("write started a conversion in hardware mode");
  AST_HW_START: assert property (
    $rose(hardware_trigger_input_i) && cfg_ff[2] && !conv_active_o
    |-> ##[2:6] conv_active_o)
    else $error("hardware start missing");
  AST_ACT_LEN: assert property (cnt_ff <= 8'(CYCLES))
    else $error("active flag held too long");
  AST_UNMAP: assert property (
    rd_i && (addr_i < ADDR_SC1 || addr_i > ADDR_EVT_MSK) |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  // main scenarios reached
  COV_SW: cover property (sc1_wr && !cfg_ff[2] && !conv_active_o);
  COV_HW: cover property ($rose(hardware_trigger_input_i) && cfg_ff[2]);
  COV_CFG: cover property (rd_i && addr_i == ADDR_SC2 && cfg_ff == 3'h7);
endmodule // atcs_top_sva

bind atcs_top atcs_top_sva #(.CYCLES(CYCLES)) u_sva (
  .core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .hardware_trigger_input_i, .rdata_o, .conv_active_o
);

// ---- bench/atcs_trig_src.sv ----
// far-side model: hardware trigger source and converter sample value
module atcs_trig_src (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       req_i,
  input  wire logic [7:0] sample_i,
  output logic            hardware_trigger_input_o,
  output logic      [7:0] conv_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] hold_ff;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) hold_ff <= 3'h0;
    else if (req_i) hold_ff <= 3'h4;
    else if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
  end
  // long enough to cross the sync, then low again
  assign hardware_trigger_input_o = (hold_ff != 3'h0);
  assign conv_data_o = sample_i;
endmodule // atcs_trig_src

// ---- bench/tb_adc_trigger_compare_status.sv ----
// self-checking bench for the trigger, compare and status block
module tb_adc_trigger_compare_status;
  import atcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cfg, lvl, smp, sc2, evt, pop;
  } atcs_row_s;
  logic       core_clk, nrst, wr, rd, src_req, hw_trig, irq, act;
  logic [7:0] addr, wdata, rdata, src_val, conv_data, q;
  int         n_mismatch, samples_checked, cyc;
  // compare cases: less-than, greater-equal and compare off
  atcs_row_s  rows [5] = '{
    '{8'h20, 8'h80, 8'h7f, 8'h20, 8'h03, 8'h7f},
    '{8'h20, 8'h80, 8'h80, 8'h28, 8'h01, 8'h00},
    '{8'h30, 8'h80, 8'h80, 8'h30, 8'h03, 8'h80},
    '{8'h30, 8'h80, 8'h7f, 8'h38, 8'h01, 8'h00},
    '{8'h00, 8'h80, 8'h55, 8'h00, 8'h01, 8'h55}};

  atcs_top #(.DEPTH(2), .CYCLES(4)) dut (
    .core_clk_i(core_clk), .nrst_i(nrst), .ce_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .hardware_trigger_input_i(hw_trig), .conv_data_i(conv_data),
    .rdata_o(rdata), .irq_o(irq), .conv_active_o(act));
  atcs_trig_src u_src (
    .core_clk_i(core_clk), .nrst_i(nrst), .req_i(src_req),
    .sample_i(src_val), .hardware_trigger_input_o(hw_trig),
    .conv_data_o(conv_data));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // bus cycles: strobes last exactly one cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait on the active flag; a stall shows up as a mismatch
  task automatic wait_act(input logic v);
    int i;
    i = 0;
    while (act !== v && i < 40) begin
      @(posedge core_clk);
      #1 i++;
    end
    chk({7'h0, act}, {7'h0, v});
  endtask

  task automatic conv;
    wait_act(1'b1);
    wait_act(1'b0);
    repeat (2) @(posedge core_clk);
  endtask

  // cycle ceiling against a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    {nrst, wr, rd, src_req, addr, wdata, src_val} = '0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(ADDR_SC2, rows[i].cfg);
      wr_reg(ADDR_CMP_LVL, rows[i].lvl);
      src_val <= rows[i].smp;
      wr_reg(ADDR_SC1, 8'h00);
      conv();
      rd_reg(ADDR_SC2, q);
      chk(q, rows[i].sc2);
      rd_reg(ADDR_EVT_ST, q);
      chk(q, rows[i].evt);
      wr_reg(ADDR_EVT_ST, 8'h07);
      rd_reg(ADDR_RESULT, q);
      chk(q, rows[i].pop);
    end
    // second reset in mid-run restores the reset value
    wr_reg(ADDR_SC2, 8'hff);
    @(posedge core_clk) nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd_reg(ADDR_SC2, q);
    chk(q, 8'h08);
    rd_reg(8'h20, q);
    chk(q, 8'h00);
    // write then read with no gap: status bits ignore the write
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= ADDR_SC2;
    wdata <= 8'hff;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(rdata, 8'h78);
    wr_reg(ADDR_SC2, 8'h00);
    // fill a two-deep queue, then push once more to overwrite
    for (int i = 1; i < 4; i++) begin
      src_val <= 8'(i * 17);
      wr_reg(ADDR_SC1, 8'h00);
      conv();
      rd_reg(ADDR_SC2, q);
      chk(q, (i == 1) ? 8'h00 : 8'h04);
    end
    rd_reg(ADDR_EVT_ST, q);
    chk(q, 8'h05);
    rd_reg(ADDR_RESULT, q);
    chk(q, 8'h22);
    rd_reg(ADDR_RESULT, q);
    chk(q, 8'h33);
    rd_reg(ADDR_SC2, q);
    chk(q, 8'h08);
    // interrupt raised, cleared, then masked
    wr_reg(ADDR_EVT_ST, 8'h07);
    wr_reg(ADDR_EVT_MSK, 8'h01);
    wr_reg(ADDR_SC1, 8'h00);
    conv();
    chk({7'h0, irq}, 8'h01);
    wr_reg(ADDR_EVT_ST, 8'h01);
    @(posedge core_clk);
    #1 chk({7'h0, irq}, 8'h00);
    wr_reg(ADDR_EVT_MSK, 8'h00);
    wr_reg(ADDR_SC1, 8'h00);
    conv();
    chk({7'h0, irq}, 8'h00);
    // hardware mode: register write must not start, pin must
    wr_reg(ADDR_EVT_ST, 8'h07);
    wr_reg(ADDR_SC2, 8'h40);
    wr_reg(ADDR_SC1, 8'h00);
    repeat (4) @(posedge core_clk);
    #1 chk({7'h0, act}, 8'h00);
    @(posedge core_clk) src_req <= 1'b1;
    @(posedge core_clk) src_req <= 1'b0;
    wait_act(1'b1);
    rd_reg(ADDR_SC2, q);
    chk(q & 8'h80, 8'h80);
    wait_act(1'b0);
    repeat (2) @(posedge core_clk);
    rd_reg(ADDR_EVT_ST, q);
    chk(q & 8'h01, 8'h01);
    complete_run;
  end
endmodule // tb_adc_trigger_compare_status

// ---- rtl/atcs_conv_seq.sv ----
// conversion sequencer: timing, active flag and result capture
module atcs_conv_seq
  import atcs_pkg::*;
#(
  parameter int W      = 8,
  parameter int CYCLES = CONV_CYCLES,
  parameter int CW     = $clog2(CYCLES + 1)
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         start_i,
  input  wire logic         abort_i,
  input  wire logic [W-1:0] conv_data_i,
  output logic              active_o,
  output logic              done_o,
  output logic      [W-1:0] result_o
);
  typedef enum logic {
    ATCS_IDLE = 1'b0,
    ATCS_CONV = 1'b1
  } atcs_seq_e;

  typedef struct packed {
    atcs_seq_e    st;
    logic [CW-1:0] cnt;
    logic          active;
    logic          done;
    logic [W-1:0]  result;
  } atcs_seq_s;

  atcs_seq_s state_ff;
  atcs_seq_s nxt_state;

  // a start in the abort cycle restarts, so start is checked last
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.done = 1'b0;
    case (state_ff.st)
      ATCS_IDLE: begin
      end
      ATCS_CONV: begin
        if (abort_i) begin
          nxt_state.st = ATCS_IDLE;
        end else if (state_ff.cnt == '0) begin
          nxt_state.st     = ATCS_IDLE;
          nxt_state.done   = 1'b1;
          nxt_state.result = conv_data_i;
        end else begin
          nxt_state.cnt = state_ff.cnt - 1'b1;
        end
      end
      default: begin
        nxt_state.st = ATCS_IDLE;
      end
    endcase
    if (start_i) begin
      nxt_state.st  = ATCS_CONV;
      nxt_state.cnt = CW'(CYCLES - 1);
    end
    nxt_state.active = (nxt_state.st == ATCS_CONV);
  end

  // sequencer register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  assign active_o = state_ff.active;
  assign done_o   = state_ff.done;
  assign result_o = state_ff.result;
endmodule // atcs_conv_seq

// ---- rtl/atcs_pkg.sv ----
// constants for the converter trigger, compare and status block
package atcs_pkg;
  // register map: base plus offsets, byte wide registers
  localparam logic [7:0] REG_BASE    = 8'h10;
  localparam logic [7:0] OFF_SC1     = 8'h00;
  localparam logic [7:0] OFF_SC2     = 8'h01;
  localparam logic [7:0] OFF_RESULT  = 8'h02;
  localparam logic [7:0] OFF_CMP_LVL = 8'h03;
  localparam logic [7:0] OFF_EVT_ST  = 8'h04;
  localparam logic [7:0] OFF_EVT_MSK = 8'h05;
  localparam logic [7:0] ADDR_SC1     = 8'(REG_BASE + OFF_SC1);
  localparam logic [7:0] ADDR_SC2     = 8'(REG_BASE + OFF_SC2);
  localparam logic [7:0] ADDR_RESULT  = 8'(REG_BASE + OFF_RESULT);
  localparam logic [7:0] ADDR_CMP_LVL = 8'(REG_BASE + OFF_CMP_LVL);
  localparam logic [7:0] ADDR_EVT_ST  = 8'(REG_BASE + OFF_EVT_ST);
  localparam logic [7:0] ADDR_EVT_MSK = 8'(REG_BASE + OFF_EVT_MSK);

  // bit positions inside converter_status_control_two
  localparam int BIT_ACTIVE  = 7;
  localparam int BIT_TRIG_HW = 6;
  localparam int BIT_CMP_EN  = 5;
  localparam int BIT_CMP_GE  = 4;
  localparam int BIT_EMPTY   = 3;
  localparam int BIT_FULL    = 2;

  // reset values
  localparam logic [7:0] SC1_RST     = 8'h00;
  localparam logic [7:0] SC2_RST     = 8'h08;
  localparam logic [7:0] CMP_LVL_RST = 8'h00;
  localparam logic [2:0] EVT_RST     = 3'h0;

  // event bits of the sticky status and mask registers
  localparam int EVT_DONE = 0;
  localparam int EVT_CMP  = 1;
  localparam int EVT_OVR  = 2;

  // conversion length in core clock cycles
  localparam int CONV_CYCLES = 16;
  // result queue depth
  localparam int QUEUE_DEPTH = 4;
endpackage : atcs_pkg

// ---- rtl/atcs_result_mem.sv ----
// small result queue storage with registered read data
module atcs_result_mem
  import atcs_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input  wire logic          core_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            q;
  } atcs_mem_s;

  atcs_mem_s state_ff;
  atcs_mem_s nxt_state;

  // write port, and read that bypasses a same-cycle write
  always_comb begin
    nxt_state = state_ff;
    if (we_i) begin
      nxt_state.mem[waddr_i] = wdata_i;
    end
    nxt_state.q = nxt_state.mem[raddr_i];
  end

  // storage register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o = state_ff.q;
endmodule // atcs_result_mem

// ---- rtl/atcs_top.sv ----
// converter trigger, compare and result queue status block
//
// Decided for this implementation: the address-and-strobe port.
module atcs_top
  import atcs_pkg::*;
#(
  parameter int W      = 8,
  parameter int DEPTH  = QUEUE_DEPTH,
  parameter int CYCLES = CONV_CYCLES
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [7:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  input  wire logic         hardware_trigger_input_i,
  input  wire logic [W-1:0] conv_data_i,
  output logic      [7:0]   rdata_o,
  output logic              irq_o,
  output logic              conv_active_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NW = $clog2(DEPTH + 1);
  localparam logic [NW-1:0] DEPTH_N = NW'(DEPTH);
  localparam logic [AW-1:0] LAST_P  = AW'(DEPTH - 1);

  typedef struct packed {
    logic [7:0]    sc1;
    logic          trig_hw;
    logic          cmp_en;
    logic          cmp_ge;
    logic [7:0]    cmp_lvl;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [NW-1:0] count;
    logic [2:0]    evt_st;
    logic [2:0]    evt_msk;
    logic          irq;
    logic [7:0]    rdata;
    logic          hwt_s1;
    logic          hwt_s2;
    logic          hwt_s3;
    logic          start;
    logic          abort;
  } atcs_state_s;

  atcs_state_s state_ff;
  atcs_state_s nxt_state;

  logic         seq_active;
  logic         seq_done;
  logic [W-1:0] seq_result;
  logic [W-1:0] mem_q;
  logic         push;
  logic         pop;
  logic         cmp_hit;
  logic         q_empty;
  logic         q_full;
  logic         hw_edge;
  logic         wr_sc1;
  logic [7:0]   sc2_view;

  // wrap-around pointer step, works for any depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_P) ? '0 : AW'(p + 1'b1);
  endfunction

  // zero-extend or trim a result to the byte bus
  function automatic logic [7:0] to_byte(input logic [W-1:0] v);
    logic [W+7:0] wide;
    wide    = {8'h00, v};
    to_byte = wide[7:0];
  endfunction

  // conversion timing lives in its own sequencer
  atcs_conv_seq #(
    .W      (W),
    .CYCLES (CYCLES)
  ) u_seq (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .start_i     (state_ff.start),
    .abort_i     (state_ff.abort),
    .conv_data_i (conv_data_i),
    .active_o    (seq_active),
    .done_o      (seq_done),
    .result_o    (seq_result)
  );

  // result queue storage
  atcs_result_mem #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .we_i       (push),
    .waddr_i    (state_ff.wr_ptr),
    .wdata_i    (seq_result),
    .raddr_i    (nxt_state.rd_ptr),
    .rdata_o    (mem_q)
  );

  // queue flags straight from the occupancy count
  // empty while nothing unread
  assign q_empty = (state_ff.count == '0);
  assign q_full  = (state_ff.count == DEPTH_N);

  // trigger edge from the second and third sync stages only
  assign hw_edge = state_ff.hwt_s2 & ~state_ff.hwt_s3;
  assign wr_sc1  = wr_i && (addr_i == ADDR_SC1);

  // compare against the level; the compare byte is zero-extended
  always_comb begin
    cmp_hit = 1'b1;
    if (state_ff.cmp_ge) begin
      cmp_hit = (to_byte(seq_result) >= state_ff.cmp_lvl);
    end else begin
      cmp_hit = (to_byte(seq_result) < state_ff.cmp_lvl);
    end
  end

  // a result is queued unless the enabled compare rejects it
  // compare gates storage
  assign push = seq_done && (!state_ff.cmp_en || cmp_hit);
  assign pop  = rd_i && (addr_i == ADDR_RESULT) && !q_empty;

  // status/control two as software sees it
  always_comb begin
    sc2_view              = 8'h00;
    sc2_view[BIT_ACTIVE]  = seq_active;
    sc2_view[BIT_TRIG_HW] = state_ff.trig_hw;
    sc2_view[BIT_CMP_EN]  = state_ff.cmp_en;
    sc2_view[BIT_CMP_GE]  = state_ff.cmp_ge;
    sc2_view[BIT_EMPTY]   = q_empty;
    sc2_view[BIT_FULL]    = q_full;
  end

  // whole next-state computation
  always_comb begin
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    nxt_state       = state_ff;
    evt_set         = 3'h0;
    evt_clr         = 3'h0;
    nxt_state.start = 1'b0;
    nxt_state.abort = 1'b0;
    nxt_state.rdata = 8'h00;

    // two-flop sync of the trigger pin plus an edge stage
    nxt_state.hwt_s1 = hardware_trigger_input_i;
    nxt_state.hwt_s2 = state_ff.hwt_s1;
    nxt_state.hwt_s3 = state_ff.hwt_s2;

    // register writes
    if (wr_i) begin
      case (addr_i)
        ADDR_SC1: begin
          nxt_state.sc1 = wdata_i;
        end
        ADDR_SC2: begin
          nxt_state.trig_hw = wdata_i[BIT_TRIG_HW];
          nxt_state.cmp_en  = wdata_i[BIT_CMP_EN];
          nxt_state.cmp_ge  = wdata_i[BIT_CMP_GE];
        end
        ADDR_CMP_LVL: begin
          nxt_state.cmp_lvl = wdata_i;
        end
        ADDR_EVT_ST: begin
          evt_clr = wdata_i[2:0];
        end
        ADDR_EVT_MSK: begin
          nxt_state.evt_msk = wdata_i[2:0];
        end
        default: begin
        end
      endcase
    end

    // a write to status/control one aborts a running conversion
    if (wr_sc1 && seq_active) begin
      nxt_state.abort = 1'b1;
    end
    if (!state_ff.trig_hw) begin
      nxt_state.start = wr_sc1;
    end else begin
      nxt_state.start = hw_edge;
    end

    // queue pointers and count; overwrite drops the oldest entry
    if (push) begin
      nxt_state.wr_ptr = ptr_inc(state_ff.wr_ptr);
    end
    if (pop) begin
      nxt_state.rd_ptr = ptr_inc(state_ff.rd_ptr);
    end
    if (push && q_full && !pop) begin
      nxt_state.rd_ptr = ptr_inc(state_ff.rd_ptr);
      evt_set[EVT_OVR] = 1'b1;
    end else if (push && !pop) begin
      nxt_state.count = NW'(state_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_state.count = NW'(state_ff.count - 1'b1);
    end

    // events; a set in the clear cycle survives
    evt_set[EVT_DONE] = seq_done;
    evt_set[EVT_CMP]  = seq_done && state_ff.cmp_en && cmp_hit;
    nxt_state.evt_st  = (state_ff.evt_st & ~evt_clr) | evt_set;
    nxt_state.irq     = |(nxt_state.evt_st & nxt_state.evt_msk);

    // read data for the cycle after the strobe; unmapped reads zero
    if (rd_i) begin
      case (addr_i)
        ADDR_SC1: begin
          nxt_state.rdata = state_ff.sc1;
        end
        ADDR_SC2: begin
          nxt_state.rdata = sc2_view;
        end
        ADDR_RESULT: begin
          nxt_state.rdata = q_empty ? 8'h00 : to_byte(mem_q);
        end
        ADDR_CMP_LVL: begin
          nxt_state.rdata = state_ff.cmp_lvl;
        end
        ADDR_EVT_ST: begin
          nxt_state.rdata = {5'h00, state_ff.evt_st};
        end
        ADDR_EVT_MSK: begin
          nxt_state.rdata = {5'h00, state_ff.evt_msk};
        end
        default: begin
          nxt_state.rdata = 8'h00;
        end
      endcase
    end
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff         <= '0;
      state_ff.sc1     <= SC1_RST;
      state_ff.trig_hw <= SC2_RST[BIT_TRIG_HW];
      state_ff.cmp_en  <= SC2_RST[BIT_CMP_EN];
      state_ff.cmp_ge  <= SC2_RST[BIT_CMP_GE];
      state_ff.cmp_lvl <= CMP_LVL_RST;
      state_ff.evt_st  <= EVT_RST;
      state_ff.evt_msk <= EVT_RST;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // outputs come from flops
  assign rdata_o       = state_ff.rdata;
  assign irq_o         = state_ff.irq;
  assign conv_active_o = seq_active;
endmodule // atcs_top
